// File: rtl/twcd_pkg.sv
/*
 * Shared constants and helpers of the touch-wheel command decoder.
 * Assumes a 100 MHz core clock and an 8-bit, MSB-first command link.
 */
`default_nettype none
package twcd_pkg;
    // ============================================================
    // timing
    localparam int CLK_MHZ            = 100;
    localparam int BURST_TIME_US      = 1000;
    localparam int CAL_BURST_TIME_US  = 52500;
    localparam int FREE_RUN_PERIOD_US = 58000;
    localparam int TIMER_W            = 23;
    // ============================================================
    // commands and operands
    localparam logic [7:0] CMD_CALIBRATE = 8'h01;
    localparam logic [7:0] CMD_DRIFT     = 8'h03;
    localparam logic [1:0] OP_NEAR       = 2'h1;
    localparam logic [1:0] OP_TOUCH      = 2'h2;
    localparam logic [5:0] THR_RESET     = 6'h0a;
    localparam logic [3:0] CAL_BURSTS    = 4'ha;
    localparam logic [3:0] DRIFT_CMDS    = 4'ha;
    localparam logic [2:0] FREE_RATIO    = 3'h6;
    localparam int         TOUCH_SHIFT   = 2;
    localparam int         HYST_SHIFT    = 3;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    // ============================================================
    // response byte layout
    localparam int   RESP_TOUCH = 7;
    localparam int   RESP_TYPE  = 6;
    localparam int   RESP_POL   = 1;
    localparam int   RESP_NEAR  = 0;
    localparam logic IS_WHEEL   = 1'b1;

    function automatic logic [2:0] bin2gray(input logic [2:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [2:0] gray2bin(input logic [2:0] g);
        return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
    endfunction
endpackage
`default_nettype wire

// File: rtl/twcd_det_if.sv
/*
 * Carrier between the command core and the detector.
 * Assumes both ends run on the core clock.
 */
`default_nettype none
interface twcd_det_if;
    logic       burst_done;
    logic       calibrating;
    logic       drift_step;
    logic [9:0] raw_level;
    logic [5:0] near_thr;
    logic [5:0] touch_thr;
    logic       touched;
    logic       near;
    logic       pol_err;
    modport core (output burst_done, calibrating, drift_step, raw_level, near_thr,
                  touch_thr, input touched, near, pol_err);
    modport det  (input burst_done, calibrating, drift_step, raw_level, near_thr,
                  touch_thr, output touched, near, pol_err);
endinterface
`default_nettype wire

// File: rtl/twcd_detector.sv
/*
 * Detector: reference level, near and touch decisions after each burst.
 * Assumes raw_level is valid on the cycle burst_done pulses.
 */
`default_nettype none
module twcd_detector
    import twcd_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    twcd_det_if.det  det
);
    logic [9:0]         reference;
    logic               touched;
    logic               near;
    logic               pol_err;
    logic [9:0]         next_reference;
    logic               next_touched;
    logic               next_near;
    logic               next_pol_err;
    logic signed [10:0] delta;
    logic signed [10:0] thr4;
    logic signed [10:0] release_lvl;

    // ============================================================
    // decision logic
    always_comb
    begin
        delta       = $signed({1'b0, det.raw_level}) - $signed({1'b0, reference});
        thr4        = $signed(11'({det.touch_thr, 2'h0}));
        release_lvl = thr4 - (thr4 >>> HYST_SHIFT);
        next_reference = reference;
        next_touched   = touched;
        next_near      = near;
        next_pol_err   = pol_err;
        if (det.burst_done)
        begin
            if (det.calibrating)
            begin
                next_reference = det.raw_level;
                next_touched   = 1'b0;
                next_near      = 1'b0;
                next_pol_err   = 1'b0;
            end
            else
            begin
                // frozen while touched so a finger is not learned away
                if (det.drift_step && !touched)
                begin
                    if (delta > 11'sd0)
                        next_reference = reference + 10'h001;
                    else if (delta < 11'sd0)
                        next_reference = reference - 10'h001;
                end
                next_near    = delta > $signed({5'h00, det.near_thr});
                next_touched = touched ? (delta >= release_lvl)
                                       : (delta > thr4);
                next_pol_err = (-delta) > thr4;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            reference <= 10'h000;
            touched   <= 1'b0;
            near      <= 1'b0;
            pol_err   <= 1'b0;
        end
        else
        begin
            reference <= next_reference;
            touched   <= next_touched;
            near      <= next_near;
            pol_err   <= next_pol_err;
        end
    end

    assign det.touched = touched;
    assign det.near    = near;
    assign det.pol_err = pol_err;

    // ============================================================
    // checks
    property p_touch_hyst;
        @(posedge clock) disable iff (reset)
        touched && det.burst_done && !det.calibrating && delta >= release_lvl |=> touched;
    endproperty
    a_touch_hyst: assert property (p_touch_hyst) else $error("touch released early");

    property p_touch_set;
        @(posedge clock) disable iff (reset)
        !touched && det.burst_done && !det.calibrating && delta > thr4 |=> touched;
    endproperty
    a_touch_set: assert property (p_touch_set) else $error("touch not set");

    property p_near_nohyst;
        @(posedge clock) disable iff (reset)
        det.burst_done && !det.calibrating && delta <= $signed({5'h00, det.near_thr})
        |=> !near;
    endproperty
    a_near_nohyst: assert property (p_near_nohyst) else $error("near held");

    property p_drift_frozen;
        @(posedge clock) disable iff (reset)
        touched && !det.calibrating |=> reference == $past(reference);
    endproperty
    a_drift_frozen: assert property (p_drift_frozen) else $error("drift while touched");
endmodule // twcd_detector
`default_nettype wire

// File: rtl/twcd_decoder.sv
/*
 * Command decoder of the touch-wheel sensor: link shifter, command
 * interpreter, burst sequencing and response byte.
 * Assumes the host is master of spi_clk (idle high) and ss_n, and an
 * acquisition front end supplying acq_level and acq_position.
 */
`default_nettype none
module twcd_decoder
    import twcd_pkg::*;
#(
    parameter int BURST_TIME_US      = twcd_pkg::BURST_TIME_US,
    parameter int CAL_BURST_TIME_US  = twcd_pkg::CAL_BURST_TIME_US,
    parameter int FREE_RUN_PERIOD_US = twcd_pkg::FREE_RUN_PERIOD_US
)
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       spi_clk,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    output logic            host_go_line,
    output logic            near_out,
    output logic            burst_active,
    input  wire logic [9:0] acq_level,
    input  wire logic [6:0] acq_position
);
    localparam int BURST_CYC = BURST_TIME_US * CLK_MHZ;
    localparam int CAL_CYC   = CAL_BURST_TIME_US * CLK_MHZ;
    localparam int FREE_CYC  = FREE_RUN_PERIOD_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_READY = 3'b001,
        ST_BURST = 3'b010,
        ST_CAL   = 3'b100
    } twcd_state_t;

    twcd_det_if det_bus ();

    // ============================================================
    // link domain: shifter, cleared by the frame's own select
    logic [2:0] bit_cnt;
    logic [6:0] rx_shift;
    logic [2:0] cnt_gray;
    logic [7:0] rx_byte;
    logic       rx_tog;

    always_ff @(posedge spi_clk or posedge ss_n or posedge reset)
    begin
        if (reset || ss_n)
        begin
            bit_cnt  <= 3'h0;
            rx_shift <= 7'h00;
            cnt_gray <= 3'h0;
        end
        else
        begin
            bit_cnt  <= bit_cnt + 3'h1;
            rx_shift <= {rx_shift[5:0], mosi};
            cnt_gray <= bin2gray(bit_cnt + 3'h1);
        end
    end

    // kept across frames so a finished byte survives the release of select
    always_ff @(posedge spi_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_byte <= 8'h00;
            rx_tog  <= 1'b0;
        end
        else if (!ss_n && bit_cnt == LAST_BIT)
        begin
            rx_byte <= {rx_shift, mosi};
            rx_tog  <= ~rx_tog;
        end
    end

    // ============================================================
    // crossings into the core clock
    logic       ss_meta;
    logic       ss_sync;
    logic       ss_prev;
    logic       tog_meta;
    logic       tog_sync;
    logic       tog_prev;
    logic [2:0] cnt_meta;
    logic [2:0] cnt_sync;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ss_meta  <= 1'b1;
            ss_sync  <= 1'b1;
            ss_prev  <= 1'b1;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_prev <= 1'b0;
            cnt_meta <= 3'h0;
            cnt_sync <= 3'h0;
        end
        else
        begin
            ss_meta  <= ss_n;
            ss_sync  <= ss_meta;
            ss_prev  <= ss_sync;
            tog_meta <= rx_tog;
            tog_sync <= tog_meta;
            tog_prev <= tog_sync;
            cnt_meta <= cnt_gray;
            cnt_sync <= cnt_meta;
        end
    end

    logic rx_event;
    logic ss_rise;
    assign rx_event = tog_sync ^ tog_prev;
    assign ss_rise  = ss_sync & ~ss_prev;

    // ============================================================
    // command interpreter and burst sequencer
    twcd_state_t        state;
    twcd_state_t        next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic [3:0]         cal_left;
    logic [3:0]         next_cal_left;
    logic [3:0]         drift_cnt;
    logic [3:0]         next_drift_cnt;
    logic [2:0]         free_cnt;
    logic [2:0]         next_free_cnt;
    logic               drift_pending;
    logic               next_drift_pending;
    logic               cal_pending;
    logic               next_cal_pending;
    logic [5:0]         near_thr;
    logic [5:0]         next_near_thr;
    logic [5:0]         touch_thr;
    logic [5:0]         next_touch_thr;
    logic               burst_done;
    logic               next_burst_done;
    logic               drift_step;
    logic               next_drift_step;
    logic [TIMER_W-1:0] burst_last;

    always_comb
    begin
        next_state         = state;
        next_timer         = timer;
        next_cal_left      = cal_left;
        next_drift_cnt     = drift_cnt;
        next_free_cnt      = free_cnt;
        next_drift_pending = drift_pending;
        next_cal_pending   = cal_pending;
        next_near_thr      = near_thr;
        next_touch_thr     = touch_thr;
        next_burst_done    = 1'b0;
        next_drift_step    = 1'b0;
        burst_last = (state == ST_CAL) ? TIMER_W'(CAL_CYC - 1) : TIMER_W'(BURST_CYC - 1);
        unique case (state)
            ST_READY:
            begin
                // bytes arriving in any other state are dropped
                if (rx_event)
                begin
                    if (rx_byte == CMD_CALIBRATE)
                        next_cal_pending = 1'b1;
                    else if (rx_byte == CMD_DRIFT)
                    begin
                        if (!det_bus.touched)
                        begin
                            if (drift_cnt == DRIFT_CMDS - 4'h1)
                            begin
                                next_drift_cnt     = 4'h0;
                                next_drift_pending = 1'b1;
                            end
                            else
                                next_drift_cnt = drift_cnt + 4'h1;
                        end
                    end
                    else if (rx_byte[7:6] == OP_NEAR)
                        next_near_thr = rx_byte[5:0];
                    else if (rx_byte[7:6] == OP_TOUCH)
                        next_touch_thr = rx_byte[5:0];
                    // anything else, the null byte included, changes nothing
                end
                if (ss_rise)
                begin
                    next_timer = '0;
                    if (next_cal_pending)
                    begin
                        next_state       = ST_CAL;
                        next_cal_left    = CAL_BURSTS;
                        next_cal_pending = 1'b0;
                    end
                    else
                        next_state = ST_BURST;
                end
                else if (ss_sync)
                begin
                    // select held high: free-running bursts
                    if (timer == TIMER_W'(FREE_CYC - 1))
                    begin
                        next_timer = '0;
                        next_state = ST_BURST;
                        if (free_cnt == FREE_RATIO - 3'h1)
                        begin
                            next_free_cnt      = 3'h0;
                            next_drift_pending = 1'b1;
                        end
                        else
                            next_free_cnt = free_cnt + 3'h1;
                    end
                    else
                        next_timer = timer + 1'b1;
                end
                else
                    next_timer = '0;
            end
            ST_BURST, ST_CAL:
            begin
                if (timer == burst_last)
                begin
                    next_timer      = '0;
                    next_burst_done = 1'b1;
                    if (state == ST_BURST)
                    begin
                        next_drift_step    = drift_pending;
                        next_drift_pending = 1'b0;
                        next_state         = ST_READY;
                    end
                    else if (cal_left == 4'h1)
                        next_state = ST_READY;
                    else
                        next_cal_left = cal_left - 4'h1;
                end
                else
                    next_timer = timer + 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state         <= ST_CAL;
            timer         <= '0;
            cal_left      <= CAL_BURSTS;
            drift_cnt     <= 4'h0;
            free_cnt      <= 3'h0;
            drift_pending <= 1'b0;
            cal_pending   <= 1'b0;
            near_thr      <= THR_RESET;
            touch_thr     <= THR_RESET;
            burst_done    <= 1'b0;
            drift_step    <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            timer         <= next_timer;
            cal_left      <= next_cal_left;
            drift_cnt     <= next_drift_cnt;
            free_cnt      <= next_free_cnt;
            drift_pending <= next_drift_pending;
            cal_pending   <= next_cal_pending;
            near_thr      <= next_near_thr;
            touch_thr     <= next_touch_thr;
            burst_done    <= next_burst_done;
            drift_step    <= next_drift_step;
        end
    end

    assign det_bus.burst_done  = burst_done;
    assign det_bus.calibrating = (state == ST_CAL);
    assign det_bus.drift_step  = drift_step;
    assign det_bus.raw_level   = acq_level;
    assign det_bus.near_thr    = near_thr;
    assign det_bus.touch_thr   = touch_thr;

    twcd_detector u_detector (
        .clock (clock),
        .reset (reset),
        .det   (det_bus.det)
    );

    // ============================================================
    // response byte and pins
    logic [7:0] resp;
    logic [7:0] next_resp;
    logic [6:0] position;

    always_comb
    begin
        // results of the last finished burst only
        if (det_bus.touched)
            next_resp = {1'b1, position};
        else
            next_resp = {1'b0, IS_WHEEL, 4'h0, det_bus.pol_err, det_bus.near};
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            resp         <= 8'h00;
            position     <= 7'h00;
            miso         <= 1'b0;
            miso_oe      <= 1'b0;
            host_go_line <= 1'b0;
            near_out     <= 1'b0;
            burst_active <= 1'b1;
        end
        else
        begin
            resp         <= next_resp;
            position     <= burst_done ? acq_position : position;
            // bit index crosses gray coded; lands well before the next rising edge
            miso         <= resp[~gray2bin(cnt_sync)];
            miso_oe      <= ~ss_sync;
            host_go_line <= (next_state == ST_READY);
            near_out     <= det_bus.near | det_bus.touched;
            burst_active <= (next_state != ST_READY);
        end
    end

    // ============================================================
    // checks
    property p_powerup_cal;
        @(posedge clock) disable iff (reset)
        $fell(reset) |-> state == ST_CAL && near_thr == THR_RESET && touch_thr == THR_RESET;
    endproperty
    a_powerup_cal: assert property (p_powerup_cal) else $error("no power-up cal");

    property p_select_burst;
        @(posedge clock) disable iff (reset)
        state == ST_READY && ss_rise |=> state != ST_READY ##0 !host_go_line;
    endproperty
    a_select_burst: assert property (p_select_burst) else $error("no burst on rise");

    property p_cal_silent;
        @(posedge clock) disable iff (reset)
        state == ST_CAL && rx_event |=> near_thr == $past(near_thr) && !cal_pending;
    endproperty
    a_cal_silent: assert property (p_cal_silent) else $error("byte taken in cal");

    property p_cal_go_low;
        @(posedge clock) disable iff (reset)
        state == ST_CAL |-> !host_go_line;
    endproperty
    a_cal_go_low: assert property (p_cal_go_low) else $error("go high in cal");

    property p_cal_end;
        @(posedge clock) disable iff (reset)
        state == ST_CAL && timer == burst_last && cal_left == 4'h1 |=> state == ST_READY;
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("cal burst count");

    property p_near_load;
        @(posedge clock) disable iff (reset)
        state == ST_READY && rx_event && rx_byte[7:6] == OP_NEAR
        |=> near_thr == $past(rx_byte[5:0]);
    endproperty
    a_near_load: assert property (p_near_load) else $error("near thr not loaded");

    property p_touch_load;
        @(posedge clock) disable iff (reset)
        state == ST_READY && rx_event && rx_byte[7:6] == OP_TOUCH
        |=> touch_thr == $past(rx_byte[5:0]);
    endproperty
    a_touch_load: assert property (p_touch_load) else $error("touch thr not loaded");

    property p_drift_tenth;
        @(posedge clock) disable iff (reset)
        state == ST_READY && rx_event && rx_byte == CMD_DRIFT && !det_bus.touched
        && drift_cnt == 4'h9 |=> drift_pending && drift_cnt == 4'h0;
    endproperty
    a_drift_tenth: assert property (p_drift_tenth) else $error("drift step missed");

    property p_drift_touched;
        @(posedge clock) disable iff (reset)
        rx_event && rx_byte == CMD_DRIFT && det_bus.touched
        |=> drift_cnt == $past(drift_cnt);
    endproperty
    a_drift_touched: assert property (p_drift_touched) else $error("drift counted");
endmodule // twcd_decoder
`default_nettype wire

// File: tb/twcd_host.sv
/* Host model: SPI master sending one command frame at a time.
   Assumes mosi is read on spi_clk rising edges, MSB first. */
`default_nettype none
module twcd_host (
    output logic      spi_clk = 1'b1,
    output logic      ss_n = 1'b1,
    output logic      mosi = 1'b0,
    input  wire logic miso,
    input  wire logic host_go_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // obey low only to probe the busy window on purpose
    task automatic xfer(input logic [7:0] c, output logic [7:0] r, input bit obey = 1'b1);
        if (obey)
            wait (host_go_line === 1'b1);
        #37 ss_n = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            spi_clk = 1'b0;
            mosi = c[i];
            #62.5 spi_clk = 1'b1;
            r[i] = miso;
            #62.5;
        end
        // released line flips so no stale bit is read
        mosi = ~mosi;
        #40 ss_n = 1'b1;
    endtask
    // select pulse with no clocks; returns once the burst has begun
    task automatic empty_frame();
        wait (host_go_line === 1'b1);
        #37 ss_n = 1'b0;
        #1000 ss_n = 1'b1;
        wait (host_go_line === 1'b0);
    endtask
endmodule // twcd_host
`default_nettype wire

// File: tb/twcd_decoder_tb.sv
/* Bench of the command decoder driven by a host model.
   Assumes bursts shortened by parameter. */
`default_nettype none
module twcd_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic [9:0] acq_level = 10'h064;
    logic [6:0] acq_position = 7'h15;
    logic [7:0] r;
    logic       spi_clk, ss_n, mosi, miso, miso_oe, host_go_line, near_out, burst_active;
    int         n, err_count = 0, compares = 0;
    always #5 clock = ~clock;
    twcd_decoder #(.BURST_TIME_US(2), .CAL_BURST_TIME_US(3), .FREE_RUN_PERIOD_US(20)) dut (
        .clock(clock), .reset(reset), .spi_clk(spi_clk), .ss_n(ss_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .host_go_line(host_go_line), .near_out(near_out),
        .burst_active(burst_active), .acq_level(acq_level), .acq_position(acq_position));
    twcd_host host (.spi_clk(spi_clk), .ss_n(ss_n), .mosi(mosi), .miso(miso),
        .host_go_line(host_go_line));
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
        compares++;
        if (v !== e)
        begin
            $display("Error %s expected %h seen %h", s, e, v);
            err_count++;
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_go();
        n = 0;
        while (host_go_line !== 1'b1)
        begin
            @(posedge clock);
            n++;
        end
        repeat (3) @(posedge clock);
    endtask
    task automatic op(input logic [7:0] c, input logic [7:0] e);
        fork
            host.xfer(c, r);
            #500 chk("oe", 8'h01, {7'h00, miso_oe});
        join
        chk("resp", e, r);
        while (host_go_line === 1'b1)
            @(posedge clock);
        @(negedge clock) chk("busy", 8'h01, {7'h00, burst_active});
        wait_go();
        chk("busy_oe", 8'h00, {6'h00, burst_active, miso_oe});
    endtask
    // ============================================================
    // tests; a new level is only seen by the next burst
    initial
    begin
        repeat (6) @(negedge clock);
        reset = 1'b0;
        chk("go", 8'h00, {7'h00, host_go_line});
        wait_go();
        chk("cal", 8'h1e, 8'(n / 100));
        op(8'h00, 8'h40);
        @(negedge clock) acq_level = 10'h06f;
        op(8'h00, 8'h40);
        op(8'h00, 8'h41);
        chk("near", 8'h01, {7'h00, near_out});
        op(8'h4c, 8'h41);
        op(8'h00, 8'h40);
        $display("test near done");
        @(negedge clock) acq_level = 10'h08d;
        op(8'h00, 8'h40);
        @(negedge clock) acq_level = 10'h088;
        op(8'h00, 8'h95);
        chk("near", 8'h01, {7'h00, near_out});
        @(negedge clock) acq_level = 10'h086;
        // drift request while touched must not count
        op(8'h03, 8'h95);
        op(8'h00, 8'h41);
        @(negedge clock) acq_level = 10'h071;
        for (int i = 0; i < 10; i++)
            op(8'h03, 8'h41);
        op(8'h00, 8'h41);
        op(8'h00, 8'h40);
        $display("test touch_drift done");
        @(negedge clock) acq_level = 10'h032;
        op(8'h00, 8'h40);
        @(negedge clock) acq_level = 10'h08c;
        host.xfer(8'h01, r);
        chk("resp", 8'h42, r);
        while (host_go_line === 1'b1)
            @(posedge clock);
        // a frame inside calibration must leave the thresholds alone
        fork
            #5000 host.xfer(8'h42, r, 1'b0);
        join_none
        wait_go();
        chk("cal", 8'h1e, 8'(n / 100));
        op(8'h00, 8'h40);
        @(negedge clock) acq_level = 10'h098;
        op(8'hc5, 8'h40);
        op(8'h00, 8'h40);
        $display("test calibrate done");
        @(negedge clock) acq_level = 10'h099;
        for (int i = 0; i < 7; i++)
        begin
            while (host_go_line === 1'b1)
                @(posedge clock);
            wait_go();
            if (i == 0)
                chk("near", 8'h01, {7'h00, near_out});
        end
        op(8'h00, 8'h40);
        @(negedge clock) acq_level = 10'h0a0;
        host.empty_frame();
        wait_go();
        op(8'h00, 8'h41);
        $display("test free_run done");
        tally_and_finish();
    end
    initial
    begin
        #600000;
        err_count++;
        $display("Error watchdog expected end seen hang");
        tally_and_finish();
    end
endmodule // twcd_decoder_tb
`default_nettype wire
